// ==== src/imv_defines.svh ====
`ifndef IMV_DEFINES_SVH
`define IMV_DEFINES_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IMV_IDX_CLR0 8'hDA
`define IMV_IDX_CLR1 8'hDB
`define IMV_IDX_CLR2 8'hDC
`define IMV_IDX_MSK2 8'hDE
`define IMV_IDX_MSK1 8'hDF
`define IMV_IDX_MSK0 8'hE0
`define IMV_IDX_SWEN 8'hE1
`define IMV_IDX_VC 8'hE2
`define IMV_IDX_IRQ_STAT 8'hF0
`define IMV_IDX_IRQ_MASK 8'hF1

// ------------------------------------------------------------
// widths, field positions, reset values
// ------------------------------------------------------------
`define IMV_ADDR_W 12
`define IMV_NSRC 10
`define IMV_GRP0_W 8
`define IMV_GRP1_W 2
`define IMV_SWEN_BIT 0
`define IMV_MSK_RST 8'h00
`define IMV_SWEN_RST 1'h0
`define IMV_SRC_RST 10'h000
`define IMV_VEC_NONE 8'h00
`define IMV_VEC_STEP 8'h04
`define IMV_RESP_OKAY 2'h0
`define IMV_RESP_SLVERR 2'h2

`endif

// ==== src/imv_pkg.sv ====
package imv_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [9:0] imv_src_type;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_GOT_ADDR = 2'b01,
        WR_GOT_DATA = 2'b10,
        WR_RESP = 2'b11
    } imv_wr_state_type;

endpackage

// ==== src/imv_top.sv ====
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "imv_defines.svh"
module imv_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [`IMV_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`IMV_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`IMV_NSRC-1:0] srcPost,
    output logic [`IMV_NSRC-1:0] srcClear,
    input wire logic svcAck,
    output logic coreIntReq,
    output logic [7:0] coreVector,
    output logic irq
);

    // ------------------------------------------------------------
    // decode and encode helpers
    // ------------------------------------------------------------
    function automatic logic isMapped(input logic [7:0] idx);
        isMapped = idx inside {`IMV_IDX_CLR0, `IMV_IDX_CLR1, `IMV_IDX_CLR2,
            `IMV_IDX_MSK2, `IMV_IDX_MSK1, `IMV_IDX_MSK0, `IMV_IDX_SWEN,
            `IMV_IDX_VC, `IMV_IDX_IRQ_STAT, `IMV_IDX_IRQ_MASK};
    endfunction

    function automatic logic [7:0] addrIndex(
        input logic [`IMV_ADDR_W-1:0] addr
    );
        addrIndex = addr[9:2];
    endfunction

    // one-hot of the lowest set bit, lowest number first
    function automatic imv_pkg::imv_src_type topOneHot(
        input imv_pkg::imv_src_type pend
    );
        imv_pkg::imv_src_type oh;
        logic found;
        oh = `IMV_SRC_RST;
        found = 1'b0;
        for (int i = 0; i < `IMV_NSRC; i++) begin
            if (pend[i] && !found) begin
                oh[i] = 1'b1;
                found = 1'b1;
            end
        end
        topOneHot = oh;
    endfunction

    // source i carries priority number i+1
    function automatic logic [7:0] vectorOf(
        input imv_pkg::imv_src_type pend
    );
        logic [7:0] v;
        logic found;
        v = `IMV_VEC_NONE;
        found = 1'b0;
        for (int i = 0; i < `IMV_NSRC; i++) begin
            if (pend[i] && !found) begin
                v = 8'((i + 1) * `IMV_VEC_STEP);
                found = 1'b1;
            end
        end
        vectorOf = v;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    imv_pkg::imv_wr_state_type wrState_r, wrState_nxt;
    logic [`IMV_ADDR_W-1:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic [`IMV_GRP0_W-1:0] mask0_r;
    logic [`IMV_GRP1_W-1:0] mask1_r;
    logic softPostSel_r;
    imv_pkg::imv_src_type posted_r, posted_nxt, irqStat_r, irqMask_r;
    imv_pkg::imv_src_type pending, pendNxt, maskAll, maskAllNxt;
    imv_pkg::imv_src_type clrMask, setMask;

    // ------------------------------------------------------------
    // write channel sequencing
    // ------------------------------------------------------------
    logic awHs, wHs, wrFire, wrLow;
    logic [`IMV_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [7:0] wrIdx;

    assign awHs = s_axi_awvalid && s_axi_awready;
    assign wHs = s_axi_wvalid && s_axi_wready;

    always_comb begin
        wrState_nxt = wrState_r;
        wrFire = 1'b0;
        unique case (wrState_r)
            imv_pkg::WR_IDLE: begin
                if (awHs && wHs) begin
                    wrState_nxt = imv_pkg::WR_RESP;
                    wrFire = 1'b1;
                end else if (awHs) begin
                    wrState_nxt = imv_pkg::WR_GOT_ADDR;
                end else if (wHs) begin
                    wrState_nxt = imv_pkg::WR_GOT_DATA;
                end
            end
            imv_pkg::WR_GOT_ADDR: begin
                if (wHs) begin
                    wrState_nxt = imv_pkg::WR_RESP;
                    wrFire = 1'b1;
                end
            end
            imv_pkg::WR_GOT_DATA: begin
                if (awHs) begin
                    wrState_nxt = imv_pkg::WR_RESP;
                    wrFire = 1'b1;
                end
            end
            imv_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    wrState_nxt = imv_pkg::WR_IDLE;
                end
            end
        endcase
    end

    // address and data taken this cycle or held from earlier
    assign wrAddr = awHs ? s_axi_awaddr : awAddr_r;
    assign wrData = wHs ? s_axi_wdata : wData_r;
    assign wrStrb = wHs ? s_axi_wstrb : wStrb_r;
    assign wrIdx = addrIndex(wrAddr);
    assign wrLow = wrFire && wrStrb[0];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wrState_r <= imv_pkg::WR_IDLE;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IMV_RESP_OKAY;
        end else begin
            wrState_r <= wrState_nxt;
            s_axi_awready <= (wrState_nxt == imv_pkg::WR_IDLE) ||
                             (wrState_nxt == imv_pkg::WR_GOT_DATA);
            s_axi_wready <= (wrState_nxt == imv_pkg::WR_IDLE) ||
                            (wrState_nxt == imv_pkg::WR_GOT_ADDR);
            s_axi_bvalid <= (wrState_nxt == imv_pkg::WR_RESP);
            if (wrFire) begin
                s_axi_bresp <= isMapped(wrIdx) ? `IMV_RESP_OKAY :
                                                 `IMV_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            awAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else begin
            if (awHs) begin
                awAddr_r <= s_axi_awaddr;
            end
            if (wHs) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
        end
    end

    // ------------------------------------------------------------
    // mask and soft post select registers
    // ------------------------------------------------------------
    logic [`IMV_GRP0_W-1:0] mask0_nxt;
    logic [`IMV_GRP1_W-1:0] mask1_nxt;
    always_comb begin
        mask0_nxt = mask0_r;
        mask1_nxt = mask1_r;
        if (wrLow && wrIdx == `IMV_IDX_MSK0) begin
            mask0_nxt = wrData[`IMV_GRP0_W-1:0];
        end
        if (wrLow && wrIdx == `IMV_IDX_MSK1) begin
            mask1_nxt = wrData[`IMV_GRP1_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask0_r <= `IMV_MSK_RST;
            mask1_r <= `IMV_GRP1_W'(`IMV_MSK_RST);
            softPostSel_r <= `IMV_SWEN_RST;
        end else begin
            mask0_r <= mask0_nxt;
            mask1_r <= mask1_nxt;
            if (wrLow && wrIdx == `IMV_IDX_SWEN) begin
                softPostSel_r <= wrData[`IMV_SWEN_BIT];
            end
        end
    end
    assign maskAll = {mask1_r, mask0_r};
    assign maskAllNxt = {mask1_nxt, mask0_nxt};

    // ------------------------------------------------------------
    // posted and pending sets
    // ------------------------------------------------------------
    imv_pkg::imv_src_type clrWrBits;
    logic clrWrHit;
    assign pending = posted_r & maskAll;
    assign clrWrHit = wrLow &&
        (wrIdx == `IMV_IDX_CLR0 || wrIdx == `IMV_IDX_CLR1);

    // the group not written keeps its posted bits
    always_comb begin
        clrWrBits = posted_r;
        if (wrIdx == `IMV_IDX_CLR0) begin
            clrWrBits[`IMV_GRP0_W-1:0] = wrData[`IMV_GRP0_W-1:0];
        end else begin
            clrWrBits[`IMV_NSRC-1:`IMV_GRP0_W] = wrData[`IMV_GRP1_W-1:0];
        end
    end

    always_comb begin
        clrMask = `IMV_SRC_RST;
        setMask = srcPost;
        if (clrWrHit && !softPostSel_r) begin
            clrMask = ~clrWrBits;
        end
        if (clrWrHit && softPostSel_r) begin
            setMask = srcPost | clrWrBits;
        end
        if (svcAck) begin
            clrMask = clrMask | topOneHot(pending);
        end
        if (wrLow && wrIdx == `IMV_IDX_VC) begin
            clrMask = {`IMV_NSRC{1'b1}};
        end
        // a new post in the clearing cycle survives
        posted_nxt = (posted_r & ~clrMask) | setMask;
    end

    // masked sources are held in the posted set regardless
    assign pendNxt = posted_nxt & maskAllNxt;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            posted_r <= `IMV_SRC_RST;
            srcClear <= `IMV_SRC_RST;
        end else begin
            posted_r <= posted_nxt;
            srcClear <= clrMask;
        end
    end

    // ------------------------------------------------------------
    // processor core side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            coreIntReq <= 1'b0;
            coreVector <= `IMV_VEC_NONE;
        end else begin
            coreIntReq <= |pendNxt;
            coreVector <= vectorOf(pendNxt);
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    imv_pkg::imv_src_type newPend, statW1c;

    assign newPend = pendNxt & ~pending;
    assign statW1c = (wrLow && wrIdx == `IMV_IDX_IRQ_STAT) ?
                     wrData[`IMV_NSRC-1:0] : `IMV_SRC_RST;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irqStat_r <= `IMV_SRC_RST;
            irqMask_r <= `IMV_SRC_RST;
            irq <= 1'b0;
        end else begin
            irqStat_r <= (irqStat_r & ~statW1c) | newPend;
            if (wrLow && wrIdx == `IMV_IDX_IRQ_MASK) begin
                irqMask_r <= wrData[`IMV_NSRC-1:0];
            end
            irq <= |(((irqStat_r & ~statW1c) | newPend) &
                     ((wrLow && wrIdx == `IMV_IDX_IRQ_MASK) ?
                      wrData[`IMV_NSRC-1:0] : irqMask_r));
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic [7:0] rdIdx;
    logic [31:0] rdMux;
    logic arHs;

    assign arHs = s_axi_arvalid && s_axi_arready;
    assign rdIdx = addrIndex(s_axi_araddr);

    always_comb begin
        rdMux = '0;
        unique case (rdIdx)
            `IMV_IDX_CLR0: rdMux[`IMV_GRP0_W-1:0] =
                posted_r[`IMV_GRP0_W-1:0];
            `IMV_IDX_CLR1: rdMux[`IMV_GRP1_W-1:0] =
                posted_r[`IMV_NSRC-1:`IMV_GRP0_W];
            `IMV_IDX_MSK0: rdMux[`IMV_GRP0_W-1:0] = mask0_r;
            `IMV_IDX_MSK1: rdMux[`IMV_GRP1_W-1:0] = mask1_r;
            `IMV_IDX_SWEN: rdMux[`IMV_SWEN_BIT] = softPostSel_r;
            `IMV_IDX_VC: rdMux[7:0] = vectorOf(pending);
            `IMV_IDX_IRQ_STAT: rdMux[`IMV_NSRC-1:0] = irqStat_r;
            `IMV_IDX_IRQ_MASK: rdMux[`IMV_NSRC-1:0] = irqMask_r;
            default: rdMux = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `IMV_RESP_OKAY;
        end else begin
            if (arHs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= isMapped(rdIdx) ? `IMV_RESP_OKAY :
                                                 `IMV_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ==== testbench/imv_checker.sv ====
`timescale 1ns/1ps
`include "imv_defines.svh"
module imv_checker (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [`IMV_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [`IMV_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [`IMV_NSRC-1:0] srcPost,
    input wire logic [`IMV_NSRC-1:0] srcClear,
    input wire logic svcAck,
    input wire logic coreIntReq,
    input wire logic [7:0] coreVector
);
    logic awTake;
    logic wTake;
    logic quiet;
    // quiet: no register write lands at this edge
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign quiet = !awTake && !wTake;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_vc_clear: assert property (
        awTake && wTake && s_axi_wstrb[0] && s_axi_awaddr[9:2] == `IMV_IDX_VC
        |=> (srcClear | $past(srcPost)) == 10'h3FF
        && (!coreIntReq || $past(srcPost) != 10'h000))
        else $error("vector write did not clear all sources");
    a_svc_clear: assert property (
        quiet && svcAck && coreIntReq && srcPost == 10'h000
        |=> srcClear == (10'h001 << ($past(coreVector[5:2]) - 4'h1)))
        else $error("service cleared the wrong source");
    a_svc_next: assert property (
        quiet && svcAck && coreIntReq && srcPost == 10'h000
        |=> coreVector == 8'h00 || coreVector > $past(coreVector))
        else $error("service did not advance to a lower priority");
    a_hold_state: assert property (
        quiet && !svcAck && srcPost == 10'h000
        |=> $stable(coreVector) && $stable(coreIntReq))
        else $error("pending state changed without a cause");
    a_post_top: assert property (
        quiet && !svcAck && coreIntReq && srcPost != 10'h000
        |=> coreIntReq && coreVector <= $past(coreVector))
        else $error("new post lowered the presented priority");
    a_none_zero: assert property (
        !coreIntReq |-> coreVector == 8'h00)
        else $error("vector not zero while nothing pending");
    a_vec_form: assert property (
        coreIntReq |-> coreVector[1:0] == 2'b00 && coreVector >= 8'h04
        && coreVector <= 8'h28)
        else $error("vector outside the source table");
    a_vec_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == `IMV_IDX_VC
        |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(coreVector)})
        else $error("vector read differs from top pending");
endmodule

// ==== testbench/imv_core_model.sv ====
`timescale 1ns/1ps
`include "imv_defines.svh"
module imv_core_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [`IMV_NSRC-1:0] postReq,
    input wire logic ackEn,
    input wire logic [3:0] ackDly,
    input wire logic coreIntReq,
    output logic [`IMV_NSRC-1:0] srcPost,
    output logic svcAck
);
    logic [3:0] waitCnt_r;
    // sources give one-cycle event pulses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            srcPost <= 10'h000;
        end else begin
            srcPost <= postReq;
        end
    end
    // core services a request ackDly+1 cycles after it first sees it, one at a time
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            waitCnt_r <= 4'h0;
            svcAck <= 1'b0;
        end else begin
            svcAck <= 1'b0;
            if (!ackEn || !coreIntReq || svcAck) begin
                waitCnt_r <= 4'h0;
            end else if (waitCnt_r == ackDly) begin
                svcAck <= 1'b1;
                waitCnt_r <= 4'h0;
            end else begin
                waitCnt_r <= waitCnt_r + 4'h1;
            end
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`include "imv_defines.svh"
module tb_top;
    logic sys_clk;
    logic rstn;
    logic [`IMV_ADDR_W-1:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [`IMV_ADDR_W-1:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic [`IMV_NSRC-1:0] srcPost;
    logic [`IMV_NSRC-1:0] srcClear;
    logic [`IMV_NSRC-1:0] postReq;
    logic svcAck;
    logic coreIntReq;
    logic [7:0] coreVector;
    logic irq;
    logic ackEn;
    logic [3:0] ackDly;
    logic [1:0] resp;
    logic [31:0] rd;
    int fails;
    int testsRun;
    int cycles;

    imv_top DUT (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .srcPost, .srcClear,
        .svcAck, .coreIntReq, .coreVector, .irq);
    imv_core_model CORE (.sys_clk, .rstn, .postReq, .ackEn, .ackDly,
        .coreIntReq, .srcPost, .svcAck);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        if (fails == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bit awGo;
        bit wGo;
        awGo = 1;
        wGo = 1;
        @(posedge sys_clk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (awGo || wGo) begin
            @(posedge sys_clk);
            if (awGo && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                awGo = 0;
            end
            if (wGo && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                wGo = 0;
            end
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] idx,
        input logic [31:0] exp);
        @(posedge sys_clk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(what, exp, rd);
    endtask

    task automatic post(input logic [9:0] bits);
        @(posedge sys_clk);
        postReq <= bits;
        @(posedge sys_clk);
        postReq <= 10'h000;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic served(input logic [7:0] v);
        do @(posedge sys_clk); while (!svcAck);
        chk("served vector", {24'h0, v}, {24'h0, coreVector});
    endtask

    task automatic t_reset();
        logic [7:0] idx [5];
        idx = '{`IMV_IDX_MSK0, `IMV_IDX_MSK1, `IMV_IDX_MSK2, `IMV_IDX_SWEN,
            `IMV_IDX_VC};
        foreach (idx[i]) begin
            rchk("reset value", idx[i], 32'h0);
        end
        rchk("unmapped read", 8'h10, 32'h0);
        chk("unmapped rresp", {30'h0, `IMV_RESP_SLVERR}, {30'h0, resp});
        wr(8'h10, 32'h0000_00FF);
        chk("unmapped bresp", {30'h0, `IMV_RESP_SLVERR}, {30'h0, resp});
        s_axi_wstrb <= 4'hE;
        wr(`IMV_IDX_MSK0, 32'h0000_00FF);
        s_axi_wstrb <= 4'hF;
        chk("strobe off bresp", {30'h0, `IMV_RESP_OKAY}, {30'h0, resp});
        rchk("strobe off write", `IMV_IDX_MSK0, 32'h0);
    endtask

    task automatic t_map();
        for (int i = 0; i < 10; i++) begin
            wr(`IMV_IDX_VC, 32'h0);
            wr(`IMV_IDX_MSK0, i < 8 ? 32'h1 << i : 32'h0);
            wr(`IMV_IDX_MSK1, i >= 8 ? 32'h1 << (i - 8) : 32'h0);
            post(10'h3FF);
            chk("vector", 32'h4 * (i + 1), {24'h0, coreVector});
        end
        rchk("posted group0", `IMV_IDX_CLR0, 32'h0000_00FF);
        rchk("posted group1", `IMV_IDX_CLR1, 32'h0000_0003);
        wr(`IMV_IDX_VC, 32'h0000_005A);
        rchk("cleared group0", `IMV_IDX_CLR0, 32'h0);
        rchk("cleared group1", `IMV_IDX_CLR1, 32'h0);
        chk("request after clear", 32'h0, {31'h0, coreIntReq});
    endtask

    task automatic t_mask();
        wr(`IMV_IDX_MSK1, 32'h0);
        wr(`IMV_IDX_MSK0, 32'h0);
        post(10'h010);
        chk("masked request", 32'h0, {31'h0, coreIntReq});
        rchk("masked posted", `IMV_IDX_CLR0, 32'h0000_0010);
        wr(`IMV_IDX_MSK0, 32'h0000_0050);
        chk("unmasked vector", 32'h14, {24'h0, coreVector});
        post(10'h042);
        chk("other bit masked", 32'h14, {24'h0, coreVector});
        wr(`IMV_IDX_MSK0, 32'h0000_0052);
        chk("higher wins", 32'h08, {24'h0, coreVector});
        rchk("vector read", `IMV_IDX_VC, 32'h0000_0008);
        wr(`IMV_IDX_VC, 32'h0);
        rchk("vector empty", `IMV_IDX_VC, 32'h0);
    endtask

    task automatic t_serve();
        wr(`IMV_IDX_MSK0, 32'h0000_00FF);
        wr(`IMV_IDX_MSK1, 32'h0000_0003);
        ackDly <= 4'h9;
        ackEn <= 1'b1;
        post(10'h010);
        post(10'h002);
        served(8'h08);
        served(8'h14);
        ackEn <= 1'b0;
        post(10'h300);
        ackDly <= 4'h0;
        ackEn <= 1'b1;
        served(8'h24);
        served(8'h28);
        repeat (3) @(posedge sys_clk);
        chk("all serviced", 32'h0, {31'h0, coreIntReq});
        ackEn <= 1'b0;
    endtask

    task automatic t_soft();
        wr(`IMV_IDX_MSK0, 32'h0);
        wr(`IMV_IDX_MSK1, 32'h0);
        wr(`IMV_IDX_CLR0, 32'h0000_00FF);
        rchk("ones ignored", `IMV_IDX_CLR0, 32'h0);
        wr(`IMV_IDX_SWEN, 32'h1);
        rchk("soft select", `IMV_IDX_SWEN, 32'h1);
        wr(`IMV_IDX_CLR0, 32'h0000_0005);
        wr(`IMV_IDX_CLR1, 32'h0000_0002);
        rchk("soft post 0", `IMV_IDX_CLR0, 32'h0000_0005);
        rchk("soft post 1", `IMV_IDX_CLR1, 32'h0000_0002);
        wr(`IMV_IDX_CLR0, 32'h0);
        rchk("zeros ignored", `IMV_IDX_CLR0, 32'h0000_0005);
        wr(`IMV_IDX_SWEN, 32'h0);
        wr(`IMV_IDX_CLR0, 32'h0000_00FE);
        rchk("zero clears", `IMV_IDX_CLR0, 32'h0000_0004);
        wr(`IMV_IDX_CLR1, 32'h0);
        rchk("zero clears 1", `IMV_IDX_CLR1, 32'h0);
    endtask

    task automatic t_irq();
        // status bits gathered by earlier scenarios are dropped first
        wr(`IMV_IDX_IRQ_STAT, 32'h0000_03FF);
        wr(`IMV_IDX_IRQ_MASK, 32'h4);
        chk("irq idle", 32'h0, {31'h0, irq});
        wr(`IMV_IDX_MSK0, 32'h4);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`IMV_IDX_IRQ_MASK, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`IMV_IDX_IRQ_MASK, 32'h4);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(`IMV_IDX_IRQ_STAT, 32'h4);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rchk("irq status", `IMV_IDX_IRQ_STAT, 32'h0);
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        rstn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        postReq = 10'h000;
        ackEn = 1'b0;
        ackDly = 4'h0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_map();
        t_mask();
        t_serve();
        t_soft();
        t_irq();
        stop_test();
    end
endmodule

bind imv_top imv_checker CHK (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .srcPost, .srcClear, .svcAck, .coreIntReq, .coreVector);
